// File: design/thermistor_pkg.sv
// Constants of the battery and thermistor status register slice.
// Assumes an 8-bit register port with byte-wide data.
package thermistor_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PACK_AND_THERMAL_STATUS = 8'h09;
  localparam logic [7:0] OFS_THERMISTOR_BIAS_CONTROL = 8'h0A;
  localparam logic [7:0] OFS_HOT_LIMIT_SIXTY         = 8'h0B;
  localparam logic [7:0] OFS_WARM_LIMIT_FORTY_FIVE   = 8'h0C;
  localparam logic [7:0] OFS_COOL_LIMIT_TEN          = 8'h0D;
  localparam logic [7:0] OFS_COLD_LIMIT_ZERO         = 8'h0E;
  localparam logic [7:0] OFS_NODE_VOLTAGE_LOW_BYTE   = 8'h0F;
  localparam logic [7:0] OFS_NODE_VOLTAGE_HIGH_BITS  = 8'h10;
  localparam logic [7:0] OFS_EVENT_STATUS            = 8'h20;
  localparam logic [7:0] OFS_EVENT_MASK              = 8'h21;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ZONE_MSB        = 7;
  localparam int ZONE_LSB        = 5;
  localparam int OV_BIT          = 4;
  localparam int UV_BIT          = 3;
  localparam int COND_MSB        = 2;
  localparam int COND_LSB        = 0;
  localparam int SELECT_MSB      = 7;
  localparam int SELECT_LSB      = 6;
  localparam int FORCE_ON_BIT    = 0;
  localparam int HIGH_BITS_MSB   = 3;
  localparam int EV_ZONE_BIT     = 0;
  localparam int EV_OV_BIT       = 1;
  localparam int EV_UV_BIT       = 2;
  localparam int EV_COND_BIT     = 3;
  localparam int EV_COUNT        = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_HOT_LIMIT   = 8'h56;
  localparam logic [7:0] RST_WARM_LIMIT  = 8'h8F;
  localparam logic [7:0] RST_COOL_LIMIT  = 8'h71;
  localparam logic [7:0] RST_COLD_LIMIT  = 8'hB4;
  localparam logic [1:0] RST_SELECT      = 2'h0;
  localparam logic       RST_FORCE_ON    = 1'h0;
  localparam logic [3:0] RST_EVENT_MASK  = 4'h0;

  // ----------------------------------------------------------------
  // Scaling of threshold codes into millivolts
  // ----------------------------------------------------------------
  localparam logic [3:0] HOT_WARM_MV_PER_CODE = 4'h2;
  localparam logic [3:0] COOL_COLD_MV_PER_CODE = 4'hA;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] ZONE_OFF  = 3'h0;
  localparam logic [2:0] ZONE_COLD = 3'h1;
  localparam logic [2:0] ZONE_COOL = 3'h2;
  localparam logic [2:0] ZONE_WARM = 3'h3;
  localparam logic [2:0] ZONE_HOT  = 3'h4;
  localparam logic [2:0] ZONE_GOOD = 3'h7;

endpackage

// File: design/sync_pair.sv
// Two-flop synchroniser for a bus of asynchronous levels.
// Assumes each bit is independently slow relative to core_clk.
`timescale 1ns/1ps
module sync_pair #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage_one <= '0;
      sync_out  <= '0;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule // sync_pair

// File: design/thermal_zone_classifier.sv
// Classifies the thermistor node voltage into a thermal zone code.
// Assumes voltage and limits are in millivolts on the same clock.
`timescale 1ns/1ps
module thermal_zone_classifier (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        bias_on,
  input  wire logic [11:0] node_mv,
  input  wire logic [11:0] hot_mv,
  input  wire logic [11:0] warm_mv,
  input  wire logic [11:0] cool_mv,
  input  wire logic [11:0] cold_mv,
  output logic      [2:0]  zone
);

  logic [2:0] next_zone;

  // A higher node voltage means a colder pack; cold is checked first.
  always_comb begin
    if (!bias_on) begin
      next_zone = thermistor_pkg::ZONE_OFF;
    end else if (node_mv > cold_mv) begin
      next_zone = thermistor_pkg::ZONE_COLD;
    end else if (node_mv > cool_mv) begin
      next_zone = thermistor_pkg::ZONE_COOL;
    end else if (node_mv < hot_mv) begin
      next_zone = thermistor_pkg::ZONE_HOT;
    end else if (node_mv < warm_mv) begin
      next_zone = thermistor_pkg::ZONE_WARM;
    end else begin
      next_zone = thermistor_pkg::ZONE_GOOD;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      zone <= thermistor_pkg::ZONE_OFF;
    end else begin
      zone <= next_zone; // R13
    end
  end

endmodule // thermal_zone_classifier

// File: design/battery_thermistor_status_regs.sv
// Battery and thermistor status registers with thermistor configuration.
// Assumes the analog front end drives its flags and the node voltage
// asynchronously, and a register master on core_clk as the only host.
//
// How it works
// R1: Status bits 7:5 report thermal zone code.
// R2: Status bit 4 mirrors overvoltage protection.
// R3: Status bit 3 mirrors undervoltage protection.
// R4: Status bits 2:0 carry pack condition code.
// R5: Control bits 7:6 select bias current.
// R6: Control bit 0 forces bias current on.
// R7: Hot limit register, reset 0x56, 2 mV.
// R8: Warm limit register, reset 0x8F, 2 mV.
// R9: Cool limit register, reset 0x71, 10 mV.
// R10: Cold limit register, reset 0xB4, 10 mV.
// R11: Low node voltage byte read only.
// R12: High node voltage nibble at next address.
// R13: Zone from voltage versus four thresholds.
// R14: Read-only status and low byte live, high nibble latched; writes to them ignored.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module battery_thermistor_status_regs #(
  parameter logic [1:0] FACTORY_SELECT = thermistor_pkg::RST_SELECT
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [7:0]  reg_rdata,
  input  wire logic        supply_valid,
  input  wire logic        overvoltage_active,
  input  wire logic        undervoltage_active,
  input  wire logic [2:0]  condition_in,
  input  wire logic [11:0] node_voltage_mv,
  output logic      [1:0]  sense_current_select,
  output logic             sense_current_enable,
  output logic             irq
);

  // ----------------------------------------------------------------
  // Front-end synchronisation
  // ----------------------------------------------------------------

  logic [11:0] node_sync;
  logic [2:0]  cond_sync;
  logic        supply_sync;
  logic        ov_sync;
  logic        uv_sync;

  sync_pair #(.WIDTH(12)) u_node_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (node_voltage_mv),
    .sync_out (node_sync)
  );

  sync_pair #(.WIDTH(6)) u_flag_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({supply_valid, overvoltage_active,
                undervoltage_active, condition_in}),
    .sync_out ({supply_sync, ov_sync, uv_sync, cond_sync})
  );

  // ----------------------------------------------------------------
  // Measurement qualification
  // ----------------------------------------------------------------

  // A multi-bit word sampled while it moves can tear, so a new voltage
  // is only accepted once two successive samples agree.
  logic [11:0] node_prev;
  logic [11:0] node_mv;
  logic [2:0]  cond_prev;
  logic [2:0]  pack_condition_code;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      node_prev <= 12'h000;
      node_mv   <= 12'h000;
    end else begin
      node_prev <= node_sync;
      if (node_prev == node_sync) begin
        node_mv <= node_sync;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cond_prev           <= 3'h0;
      pack_condition_code <= 3'h0;
    end else begin
      cond_prev <= cond_sync;
      if (cond_prev == cond_sync) begin
        pack_condition_code <= cond_sync; // R4
      end
    end
  end

  logic pack_overvoltage_flag;
  logic pack_undervoltage_flag;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pack_overvoltage_flag  <= 1'b0;
      pack_undervoltage_flag <= 1'b0;
    end else begin
      pack_overvoltage_flag  <= ov_sync; // R2
      pack_undervoltage_flag <= uv_sync; // R3
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  logic hit_status;
  logic hit_control;
  logic hit_hot;
  logic hit_warm;
  logic hit_cool;
  logic hit_cold;
  logic hit_low;
  logic hit_high;
  logic hit_events;
  logic hit_mask;

  assign hit_status  = reg_addr == thermistor_pkg::OFS_PACK_AND_THERMAL_STATUS;
  assign hit_control = reg_addr == thermistor_pkg::OFS_THERMISTOR_BIAS_CONTROL;
  assign hit_hot     = reg_addr == thermistor_pkg::OFS_HOT_LIMIT_SIXTY;
  assign hit_warm    = reg_addr == thermistor_pkg::OFS_WARM_LIMIT_FORTY_FIVE;
  assign hit_cool    = reg_addr == thermistor_pkg::OFS_COOL_LIMIT_TEN;
  assign hit_cold    = reg_addr == thermistor_pkg::OFS_COLD_LIMIT_ZERO;
  assign hit_low     = reg_addr == thermistor_pkg::OFS_NODE_VOLTAGE_LOW_BYTE;
  assign hit_high    = reg_addr == thermistor_pkg::OFS_NODE_VOLTAGE_HIGH_BITS;
  assign hit_events  = reg_addr == thermistor_pkg::OFS_EVENT_STATUS;
  assign hit_mask    = reg_addr == thermistor_pkg::OFS_EVENT_MASK;

  // ----------------------------------------------------------------
  // Thermistor bias control
  // ----------------------------------------------------------------

  logic sense_current_force_on;

  // Only bits 7:6 and 0 are storage; bits 5:1 are dropped on write.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sense_current_select   <= FACTORY_SELECT;
      sense_current_force_on <= thermistor_pkg::RST_FORCE_ON;
    end else if (reg_write && hit_control) begin
      sense_current_select   <= reg_wdata[thermistor_pkg::SELECT_MSB:
                                          thermistor_pkg::SELECT_LSB]; // R5
      sense_current_force_on <= reg_wdata[thermistor_pkg::FORCE_ON_BIT]; // R6
    end
  end

  // The source follows the supply unless software holds it on.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sense_current_enable <= 1'b0;
    end else begin
      sense_current_enable <= supply_sync | sense_current_force_on; // R6
    end
  end

  // ----------------------------------------------------------------
  // Temperature thresholds
  // ----------------------------------------------------------------

  logic [7:0] hot_limit_sixty;
  logic [7:0] warm_limit_forty_five;
  logic [7:0] cool_limit_ten;
  logic [7:0] cold_limit_zero;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hot_limit_sixty <= thermistor_pkg::RST_HOT_LIMIT;
    end else if (reg_write && hit_hot) begin
      hot_limit_sixty <= reg_wdata; // R7
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      warm_limit_forty_five <= thermistor_pkg::RST_WARM_LIMIT;
    end else if (reg_write && hit_warm) begin
      warm_limit_forty_five <= reg_wdata; // R8
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cool_limit_ten <= thermistor_pkg::RST_COOL_LIMIT;
    end else if (reg_write && hit_cool) begin
      cool_limit_ten <= reg_wdata; // R9
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cold_limit_zero <= thermistor_pkg::RST_COLD_LIMIT;
    end else if (reg_write && hit_cold) begin
      cold_limit_zero <= reg_wdata; // R10
    end
  end

  // Limits scaled into millivolts: 2 mV per code for hot and warm,
  // 10 mV per code for cool and cold.
  logic [11:0] hot_mv;
  logic [11:0] warm_mv;
  logic [11:0] cool_mv;
  logic [11:0] cold_mv;

  assign hot_mv  = 12'(hot_limit_sixty * thermistor_pkg::HOT_WARM_MV_PER_CODE);
  assign warm_mv = 12'(warm_limit_forty_five
                       * thermistor_pkg::HOT_WARM_MV_PER_CODE); // R8
  assign cool_mv = 12'(cool_limit_ten
                       * thermistor_pkg::COOL_COLD_MV_PER_CODE); // R9
  assign cold_mv = 12'(cold_limit_zero
                       * thermistor_pkg::COOL_COLD_MV_PER_CODE); // R10

  // ----------------------------------------------------------------
  // Thermal zone
  // ----------------------------------------------------------------

  logic [2:0] thermal_zone_code;

  thermal_zone_classifier u_zone (
    .core_clk (core_clk),
    .rst      (rst),
    .bias_on  (sense_current_enable),
    .node_mv  (node_mv),
    .hot_mv   (hot_mv),
    .warm_mv  (warm_mv),
    .cool_mv  (cool_mv),
    .cold_mv  (cold_mv),
    .zone     (thermal_zone_code)
  );

  // ----------------------------------------------------------------
  // Node voltage readback
  // ----------------------------------------------------------------

  // Reading the low byte freezes the high nibble so that a low-then-high
  // pair of reads forms one coherent 12-bit sample.
  logic [3:0] node_voltage_high_bits;
  logic [7:0] node_voltage_low_bits;

  assign node_voltage_low_bits = node_mv[7:0]; // R11

  always_ff @(posedge core_clk) begin
    if (rst) begin
      node_voltage_high_bits <= 4'h0;
    end else if (reg_read && hit_low) begin
      node_voltage_high_bits <= node_mv[11:8]; // R12
    end
  end

  // ----------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------

  logic [2:0] zone_prev;
  logic       ov_prev;
  logic       uv_prev;
  logic [2:0] cond_seen;
  logic [3:0] event_hit;
  logic [3:0] event_status;
  logic [3:0] event_mask;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      zone_prev <= thermistor_pkg::ZONE_OFF;
      ov_prev   <= 1'b0;
      uv_prev   <= 1'b0;
      cond_seen <= 3'h0;
    end else begin
      zone_prev <= thermal_zone_code;
      ov_prev   <= pack_overvoltage_flag;
      uv_prev   <= pack_undervoltage_flag;
      cond_seen <= pack_condition_code;
    end
  end

  always_comb begin
    event_hit = 4'h0;
    event_hit[thermistor_pkg::EV_ZONE_BIT] = zone_prev != thermal_zone_code;
    event_hit[thermistor_pkg::EV_OV_BIT]   = pack_overvoltage_flag & ~ov_prev;
    event_hit[thermistor_pkg::EV_UV_BIT]   = pack_undervoltage_flag & ~uv_prev;
    event_hit[thermistor_pkg::EV_COND_BIT] = cond_seen != pack_condition_code;
  end

  // A read clears the sticky bits, but an event in the same cycle wins.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      event_status <= 4'h0;
    end else if (reg_read && hit_events) begin
      event_status <= event_hit;
    end else begin
      event_status <= event_status | event_hit;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      event_mask <= thermistor_pkg::RST_EVENT_MASK;
    end else if (reg_write && hit_mask) begin
      event_mask <= reg_wdata[thermistor_pkg::EV_COUNT-1:0];
    end
  end

  assign irq = |(event_status & event_mask);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------

  // Status and low-byte words are assembled from live state, the high nibble from its latch; writes
  // to these offsets fall through every storage decode above.
  logic [7:0] status_word;
  logic [7:0] control_word;
  logic [7:0] next_rdata;

  always_comb begin
    status_word = 8'h00;
    status_word[thermistor_pkg::ZONE_MSB:thermistor_pkg::ZONE_LSB] =
      thermal_zone_code; // R1
    status_word[thermistor_pkg::OV_BIT] = pack_overvoltage_flag; // R2
    status_word[thermistor_pkg::UV_BIT] = pack_undervoltage_flag; // R3
    status_word[thermistor_pkg::COND_MSB:thermistor_pkg::COND_LSB] =
      pack_condition_code; // R4
  end

  always_comb begin
    control_word = 8'h00;
    control_word[thermistor_pkg::SELECT_MSB:thermistor_pkg::SELECT_LSB] =
      sense_current_select;
    control_word[thermistor_pkg::FORCE_ON_BIT] = sense_current_force_on;
  end

  always_comb begin
    next_rdata = 8'h00;
    if (hit_status) begin
      next_rdata = status_word; // R14
    end else if (hit_control) begin
      next_rdata = control_word;
    end else if (hit_hot) begin
      next_rdata = hot_limit_sixty;
    end else if (hit_warm) begin
      next_rdata = warm_limit_forty_five;
    end else if (hit_cool) begin
      next_rdata = cool_limit_ten;
    end else if (hit_cold) begin
      next_rdata = cold_limit_zero;
    end else if (hit_low) begin
      next_rdata = node_voltage_low_bits; // R11
    end else if (hit_high) begin
      next_rdata = {4'h0, node_voltage_high_bits}; // R12
    end else if (hit_events) begin
      next_rdata = {4'h0, event_status};
    end else if (hit_mask) begin
      next_rdata = {4'h0, event_mask};
    end
  end

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // battery_thermistor_status_regs

// File: verification/battery_thermistor_status_props.sv
// Concurrent checks on the ports of the battery and thermistor register slice.
// Assumes one clock domain and a master that never raises both strobes.
`timescale 1ns/1ps
module battery_thermistor_status_props (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       overvoltage_active,
  input wire logic       undervoltage_active,
  input wire logic [1:0] sense_current_select,
  input wire logic       sense_current_enable,
  input wire logic       irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_rdata_idle;
    !$past(reg_read) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside a read answer");

  property p_select;
    reg_write && reg_addr == 8'h0A |=>
      sense_current_select == $past(reg_wdata[7:6]);
  endproperty
  a_select: assert property (p_select)
    else $error("current select does not follow control write");

  property p_force_on;
    reg_write && reg_addr == 8'h0A && reg_wdata[0] |-> ##2 sense_current_enable;
  endproperty
  a_force_on: assert property (p_force_on)
    else $error("forced bias current not enabled");

  property p_limit_rb;
    reg_write && reg_addr inside {[8'h0B:8'h0E]} ##2
      reg_read && reg_addr == $past(reg_addr, 2) |=>
      reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_limit_rb: assert property (p_limit_rb)
    else $error("limit register read back differs from write");

  property p_ctrl_resv;
    reg_read && reg_addr == 8'h0A |=> reg_rdata[5:1] == 5'h00;
  endproperty
  a_ctrl_resv: assert property (p_ctrl_resv)
    else $error("reserved control bits read non zero");

  property p_high_resv;
    reg_read && reg_addr == 8'h10 |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_high_resv: assert property (p_high_resv)
    else $error("upper bits of high voltage nibble read non zero");

  property p_unmapped;
    reg_read && !(reg_addr inside {[8'h09:8'h10], 8'h20, 8'h21}) |=>
      reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped offset read non zero");

  property p_flags;
    ($stable(overvoltage_active) && $stable(undervoltage_active))[*4] ##0
      (reg_read && reg_addr == 8'h09) |=>
      reg_rdata[4:3] == {$past(overvoltage_active), $past(undervoltage_active)};
  endproperty
  a_flags: assert property (p_flags)
    else $error("protection flags in status differ from inputs");

  property p_mask_off;
    reg_write && reg_addr == 8'h21 && reg_wdata[3:0] == 4'h0 |=> !irq;
  endproperty
  a_mask_off: assert property (p_mask_off)
    else $error("interrupt high with all events masked");
endmodule // battery_thermistor_status_props

bind battery_thermistor_status_regs battery_thermistor_status_props
  battery_thermistor_status_props_inst (
  .core_clk             (core_clk),
  .rst                  (rst),
  .reg_addr             (reg_addr),
  .reg_wdata            (reg_wdata),
  .reg_write            (reg_write),
  .reg_read             (reg_read),
  .reg_rdata            (reg_rdata),
  .overvoltage_active   (overvoltage_active),
  .undervoltage_active  (undervoltage_active),
  .sense_current_select (sense_current_select),
  .sense_current_enable (sense_current_enable),
  .irq                  (irq)
);

// File: verification/test_battery_thermistor_status_regs.sv
// Self-checking bench for the battery and thermistor register slice.
// Assumes the default factory select of 00 and a 25 MHz core clock.
`timescale 1ns/1ps
module test_battery_thermistor_status_regs;
  logic        core_clk            = 1'b0;
  logic        rst                 = 1'b1;
  logic [7:0]  reg_addr            = 8'h00;
  logic [7:0]  reg_wdata           = 8'h00;
  logic        reg_write           = 1'b0;
  logic        reg_read            = 1'b0;
  logic        supply_valid        = 1'b0;
  logic        overvoltage_active  = 1'b0;
  logic        undervoltage_active = 1'b0;
  logic [2:0]  condition_in        = 3'h0;
  logic [11:0] node_voltage_mv     = 12'h000;
  logic [7:0]  reg_rdata;
  logic [1:0]  sense_current_select;
  logic        sense_current_enable;
  logic        irq;
  logic [7:0]  rd_val;
  int          err_total           = 0;
  int          total_checks        = 0;

  always #20 core_clk = ~core_clk;

  battery_thermistor_status_regs battery_thermistor_status_regs_inst (
    .core_clk             (core_clk),
    .rst                  (rst),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_write            (reg_write),
    .reg_read             (reg_read),
    .reg_rdata            (reg_rdata),
    .supply_valid         (supply_valid),
    .overvoltage_active   (overvoltage_active),
    .undervoltage_active  (undervoltage_active),
    .condition_in         (condition_in),
    .node_voltage_mv      (node_voltage_mv),
    .sense_current_select (sense_current_select),
    .sense_current_enable (sense_current_enable),
    .irq                  (irq)
  );

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task give_verdict;
    if (err_total == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task chk_pin(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task rd(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    chk8(rd_val, exp);
  endtask

  task wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (irq !== 1'b1) begin
      err_total++;
      $display("FAIL %0t got %h exp %h", $time, irq, 1'b1);
      give_verdict;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    rd_chk(thermistor_pkg::OFS_HOT_LIMIT_SIXTY, 8'h56);
    rd_chk(thermistor_pkg::OFS_WARM_LIMIT_FORTY_FIVE, 8'h8F);
    rd_chk(thermistor_pkg::OFS_COOL_LIMIT_TEN, 8'h71);
    rd_chk(thermistor_pkg::OFS_COLD_LIMIT_ZERO, 8'hB4);
    rd_chk(thermistor_pkg::OFS_THERMISTOR_BIAS_CONTROL, 8'h00);
    rd_chk(thermistor_pkg::OFS_EVENT_MASK, 8'h00);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h11, 8'h00);
    chk_pin(sense_current_select, 2'h0);
    chk_pin({irq, sense_current_enable}, 2'h0);
  endtask

  task t_zone;
    logic [11:0] mv [5];
    logic [2:0]  zc [5];
    mv = '{12'h7D0, 12'h5DC, 12'h1F4, 12'h0FA, 12'h064};
    zc = '{3'h1, 3'h2, 3'h7, 3'h3, 3'h4};
    @(posedge core_clk);
    supply_valid <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk);
      node_voltage_mv <= mv[i];
      idle(8);
      rd_chk(thermistor_pkg::OFS_PACK_AND_THERMAL_STATUS, {zc[i], 5'h00});
    end
    chk_pin({1'b0, sense_current_enable}, 2'h1);
    wr(thermistor_pkg::OFS_HOT_LIMIT_SIXTY, 8'hC8);
    @(posedge core_clk);
    node_voltage_mv <= 12'h12C;
    idle(8);
    rd_chk(thermistor_pkg::OFS_PACK_AND_THERMAL_STATUS, 8'h80);
    @(posedge core_clk);
    supply_valid <= 1'b0;
    idle(8);
    rd_chk(thermistor_pkg::OFS_PACK_AND_THERMAL_STATUS, 8'h00);
    chk_pin({1'b0, sense_current_enable}, 2'h0);
  endtask

  task t_status;
    logic [2:0] c;
    for (int i = 0; i < 5; i++) begin
      c = 3'(i);
      @(posedge core_clk);
      condition_in        <= c;
      overvoltage_active  <= c[0];
      undervoltage_active <= c[1];
      idle(8);
      rd_chk(thermistor_pkg::OFS_PACK_AND_THERMAL_STATUS,
             {3'h0, c[0], c[1], c});
    end
    wr(thermistor_pkg::OFS_PACK_AND_THERMAL_STATUS, 8'hFF);
    rd_chk(thermistor_pkg::OFS_PACK_AND_THERMAL_STATUS, 8'h04);
    @(posedge core_clk);
    condition_in        <= 3'h0;
    overvoltage_active  <= 1'b0;
    undervoltage_active <= 1'b0;
    idle(8);
  endtask

  // The high nibble is latched by the low-byte read, so order matters.
  task t_voltage;
    @(posedge core_clk);
    node_voltage_mv <= 12'hABC;
    idle(8);
    wr(thermistor_pkg::OFS_NODE_VOLTAGE_LOW_BYTE, 8'hFF);
    rd_chk(thermistor_pkg::OFS_NODE_VOLTAGE_LOW_BYTE, 8'hBC);
    rd_chk(thermistor_pkg::OFS_NODE_VOLTAGE_HIGH_BITS, 8'h0A);
    @(posedge core_clk);
    node_voltage_mv <= 12'h5A3;
    idle(8);
    rd_chk(thermistor_pkg::OFS_NODE_VOLTAGE_HIGH_BITS, 8'h0A);
    rd_chk(thermistor_pkg::OFS_NODE_VOLTAGE_LOW_BYTE, 8'hA3);
    rd_chk(thermistor_pkg::OFS_NODE_VOLTAGE_HIGH_BITS, 8'h05);
  endtask

  task t_limits;
    logic [7:0] a;
    for (int i = 0; i < 4; i++) begin
      a = thermistor_pkg::OFS_HOT_LIMIT_SIXTY + 8'(i);
      wr(a, 8'h00);
      rd_chk(a, 8'h00);
      wr(a, 8'hFF);
      rd_chk(a, 8'hFF);
    end
  endtask

  task t_control;
    logic [1:0] s;
    for (int i = 0; i < 4; i++) begin
      s = 2'(i);
      wr(thermistor_pkg::OFS_THERMISTOR_BIAS_CONTROL, {s, 5'h1F, s[0]});
      rd_chk(thermistor_pkg::OFS_THERMISTOR_BIAS_CONTROL,
             {s, 5'h00, s[0]});
      chk_pin(sense_current_select, s);
      chk_pin({1'b0, sense_current_enable}, {1'b0, s[0]});
    end
    wr(thermistor_pkg::OFS_THERMISTOR_BIAS_CONTROL, 8'h00);
  endtask

  // A masked event must still be recorded, only the output stays low.
  task t_irq;
    idle(8);
    rd(thermistor_pkg::OFS_EVENT_STATUS);
    wr(thermistor_pkg::OFS_EVENT_MASK, 8'h02);
    @(posedge core_clk);
    overvoltage_active <= 1'b1;
    wait_irq;
    rd_chk(thermistor_pkg::OFS_EVENT_STATUS, 8'h02);
    chk_pin({1'b0, irq}, 2'h0);
    wr(thermistor_pkg::OFS_EVENT_MASK, 8'h00);
    @(posedge core_clk);
    undervoltage_active <= 1'b1;
    idle(8);
    chk_pin({1'b0, irq}, 2'h0);
    rd_chk(thermistor_pkg::OFS_EVENT_STATUS, 8'h04);
  endtask

  initial begin
    idle(20);
    rst <= 1'b0;
    t_reset;
    t_zone;
    t_status;
    t_voltage;
    t_limits;
    t_control;
    t_irq;
    give_verdict;
  end
endmodule // test_battery_thermistor_status_regs
